// *** hdl/bdsrp_sync.sv ***
`timescale 1ns/10ps
module bdsrp_sync #(
	parameter int WIDTH = 1,
	parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
	// Clock and reset.
	input wire logic sys_clk_in,
	input wire logic rstn_in,
	// Asynchronous levels in, synchronised levels out.
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] meta;

	always_ff @(posedge sys_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			meta <= RESET_VAL;
			sync_out <= RESET_VAL;
		end else begin
			meta <= async_in;
			sync_out <= meta;
		end
	end

endmodule

// *** hdl/bdsrp_top.sv ***
`timescale 1ns/10ps
module bdsrp_top (
	// Clock and reset.
	input wire logic sys_clk_in,
	input wire logic rstn_in,
	// Serial link pins.
	input wire logic serial_clock_in,
	input wire logic select_strobe_low_in,
	input wire logic serial_input_line_in,
	output logic serial_output_line_out,
	output logic serial_output_line_oe_out,
	// Monitor and diagnostic events.
	input wire logic [11:0] monitor_fault_in,
	input wire bdsrp_pkg::bdsrp_diag_t diag_set_in,
	// Configuration and flags.
	output bdsrp_pkg::bdsrp_cfg_t config_out,
	output logic serial_error_flag_out
);

	// ********************************
	// Pin synchronisers and edges.
	// ********************************
	logic [2:0] pins_s;
	logic strb_s;
	logic sck_s;
	logic din_s;
	logic strb_d;
	logic sck_d;
	logic active;
	logic fall_evt;
	logic end_evt;
	logic rise;
	logic fallck;
	bdsrp_sync #(.WIDTH(3), .RESET_VAL(3'h4)) u_sync (
		.sys_clk_in(sys_clk_in),
		.rstn_in(rstn_in),
		.async_in({select_strobe_low_in, serial_clock_in, serial_input_line_in}),
		.sync_out(pins_s)
	);
	assign strb_s = pins_s[2];
	assign sck_s = pins_s[1];
	assign din_s = pins_s[0];
	always_ff @(posedge sys_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			strb_d <= 1'b1;
			sck_d <= 1'b0;
		end else begin
			strb_d <= strb_s;
			sck_d <= sck_s;
		end
	end

	// RULE2 gate on strobe
	assign active = ~strb_s;
	assign fall_evt = strb_d & ~strb_s;
	assign end_evt = ~strb_d & strb_s;
	assign rise = active & ~fall_evt & sck_s & ~sck_d;
	assign fallck = active & ~fall_evt & ~sck_s & sck_d;
	function automatic logic odd_par(input logic [14:0] bits);
		odd_par = ~^bits;
	endfunction
	function automatic logic is_ro(input logic [3:0] addr);
		is_ro = (addr == bdsrp_pkg::ADDR_RO0) || (addr == bdsrp_pkg::ADDR_RO1) ||
			(addr == bdsrp_pkg::ADDR_RO2) || (addr == bdsrp_pkg::ADDR_RO3) ||
			(addr == bdsrp_pkg::ADDR_RO4);
	endfunction
	function automatic logic [2:0] ro_index(input logic [3:0] addr);
		case (addr)
			bdsrp_pkg::ADDR_RO1: ro_index = 3'h1;
			bdsrp_pkg::ADDR_RO2: ro_index = 3'h2;
			bdsrp_pkg::ADDR_RO3: ro_index = 3'h3;
			bdsrp_pkg::ADDR_RO4: ro_index = 3'h4;
			default: ro_index = 3'h0;
		endcase
	endfunction

	// ********************************
	// Input shift register and edge count.
	// ********************************
	logic [15:0] shift_in;
	logic [4:0] rx_cnt;
	logic [3:0] rx_addr;
	logic rx_wr;
	logic frame_ok;
	logic frame_bad;
	logic status_clear;

	always_ff @(posedge sys_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			shift_in <= 16'h0000;
		// RULE1 shift on rise
		end else if (rise) begin
			shift_in <= {shift_in[14:0], din_s};
		end
	end
	always_ff @(posedge sys_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			rx_cnt <= 5'h00;
		// RULE24 clear at fall
		end else if (fall_evt) begin
			rx_cnt <= 5'h00;
		end else if (rise && rx_cnt != bdsrp_pkg::RX_CNT_OVER) begin
			rx_cnt <= rx_cnt + 5'h01;
		end
	end

	// RULE7 address and flag
	assign rx_addr = shift_in[bdsrp_pkg::ADDR_MSB:bdsrp_pkg::ADDR_LSB];
	assign rx_wr = shift_in[bdsrp_pkg::WR_BIT];
	// RULE4 commit on strobe rise
	assign frame_ok = end_evt && (rx_cnt == bdsrp_pkg::RX_CNT_FULL);
	// RULE21 no edges is no error
	assign frame_bad = end_evt && (rx_cnt != bdsrp_pkg::RX_CNT_FULL) && (rx_cnt != 5'h00);
	assign status_clear = frame_ok && rx_wr;

	// ********************************
	// Configuration registers.
	// ********************************
	logic [9:0] cfg_reg [3];

	always_ff @(posedge sys_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			cfg_reg[0] <= bdsrp_pkg::TIMING_RESET;
			cfg_reg[1] <= bdsrp_pkg::OC_LS_RESET;
			cfg_reg[2] <= bdsrp_pkg::QUAL_HS_RESET;
		// RULE8 store data bits
		end else if (status_clear) begin
			if (rx_addr == bdsrp_pkg::ADDR_TIMING) begin
				cfg_reg[0] <= shift_in[bdsrp_pkg::DATA_MSB:bdsrp_pkg::DATA_LSB];
			end
			if (rx_addr == bdsrp_pkg::ADDR_OC_LS) begin
				cfg_reg[1] <= shift_in[bdsrp_pkg::DATA_MSB:bdsrp_pkg::DATA_LSB];
			end
			if (rx_addr == bdsrp_pkg::ADDR_QUAL_HS) begin
				cfg_reg[2] <= shift_in[bdsrp_pkg::DATA_MSB:bdsrp_pkg::DATA_LSB];
			end
		end
	end

	// RULE17 timing fields
	assign config_out.overcurrent_verify_time =
		{1'b0, cfg_reg[0][bdsrp_pkg::VERIFY_MSB:bdsrp_pkg::VERIFY_LSB]};
	assign config_out.dead_time_setting = cfg_reg[0][bdsrp_pkg::DEAD_MSB:0];
	// RULE18 threshold fields
	assign config_out.overcurrent_threshold = cfg_reg[1][bdsrp_pkg::OC_MSB:bdsrp_pkg::OC_LSB];
	assign config_out.lowside_drain_threshold = cfg_reg[1][bdsrp_pkg::LS_MSB:0];
	// RULE19 qualifier selectors
	assign config_out.overcurrent_qualifier_select = cfg_reg[2][bdsrp_pkg::OC_QUAL_BIT];
	assign config_out.drain_source_qualifier_select = cfg_reg[2][bdsrp_pkg::DS_QUAL_BIT];
	// RULE20 supply and high side
	assign config_out.bridge_disconnect_threshold =
		cfg_reg[2][bdsrp_pkg::DISC_MSB:bdsrp_pkg::DISC_LSB];
	assign config_out.highside_drain_threshold = cfg_reg[2][bdsrp_pkg::HS_MSB:0];

	// ********************************
	// Read-only result registers.
	// ********************************
	logic [9:0] ro_reg [5];

	always_ff @(posedge sys_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			for (int i = 0; i < 5; i++) begin
				ro_reg[i] <= 10'h000;
			end
		end else begin
			for (int i = 0; i < 5; i++) begin
				// RULE15 clear after read
				if (frame_ok && !rx_wr && is_ro(rx_addr) && ro_index(rx_addr) == 3'(i)) begin
					ro_reg[i] <= diag_set_in[i];
				end else begin
					ro_reg[i] <= ro_reg[i] | diag_set_in[i];
				end
			end
		end
	end

	// ********************************
	// Status word.
	// ********************************
	logic por_flag;
	logic err_flag;
	logic [11:0] mon_latch;
	logic [15:0] status_word;

	always_ff @(posedge sys_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			por_flag <= 1'b1;
			mon_latch <= 12'h000;
		// RULE14 clear status after write
		end else if (status_clear) begin
			por_flag <= 1'b0;
			mon_latch <= monitor_fault_in;
		end else begin
			mon_latch <= mon_latch | monitor_fault_in;
		end
	end

	always_ff @(posedge sys_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			err_flag <= 1'b0;
		// RULE5 flag bad frame
		end else if (frame_bad) begin
			err_flag <= 1'b1;
		// RULE6 cleared by valid write
		end else if (status_clear) begin
			err_flag <= 1'b0;
		end
	end

	// RULE23 summary of all bits
	assign status_word = {|{por_flag, err_flag, mon_latch}, por_flag, err_flag, mon_latch, 1'b0};
	assign serial_error_flag_out = err_flag;

	// ********************************
	// Output word and serial output.
	// ********************************
	logic [15:0] tx_word;
	logic [3:0] tx_idx;
	logic [9:0] rd_data;

	always_comb begin
		rd_data = 10'h000;
		case (shift_in[3:0])
			bdsrp_pkg::ADDR_TIMING: rd_data = cfg_reg[0];
			bdsrp_pkg::ADDR_OC_LS: rd_data = cfg_reg[1];
			bdsrp_pkg::ADDR_QUAL_HS: rd_data = cfg_reg[2];
			default: begin
				if (is_ro(shift_in[3:0])) begin
					rd_data = ro_reg[ro_index(shift_in[3:0])];
				end
			end
		endcase
	end

	always_ff @(posedge sys_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			tx_word <= 16'h0000;
		// RULE10 RULE22 status, odd parity
		end else if (fall_evt) begin
			tx_word <= {status_word[15:1], odd_par(status_word[15:1])};
		// RULE9 RULE16 read keeps status top
		end else if (rise && rx_cnt == bdsrp_pkg::RX_CNT_WR && !din_s) begin
			// RULE10 RULE11 fresh odd parity
			tx_word[10:0] <= {rd_data, odd_par({tx_word[15:11], rd_data})};
		end
	end

	always_ff @(posedge sys_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			tx_idx <= 4'h0;
		end else if (fall_evt) begin
			tx_idx <= 4'h0;
		// RULE12 advance on fall
		end else if (fallck && tx_idx != bdsrp_pkg::TX_IDX_LAST) begin
			tx_idx <= tx_idx + 4'h1;
		end
	end

	always_ff @(posedge sys_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			serial_output_line_out <= 1'b0;
			serial_output_line_oe_out <= 1'b0;
		end else begin
			// RULE3 release when idle
			serial_output_line_oe_out <= active;
			// RULE13 summary first
			if (fall_evt) begin
				serial_output_line_out <= status_word[bdsrp_pkg::ST_SUMMARY];
			end else begin
				serial_output_line_out <= active & tx_word[bdsrp_pkg::TX_IDX_LAST - tx_idx];
			end
		end
	end

	// ********************************
	// Assertions.
	// ********************************
	default clocking cb @(posedge sys_clk_in);
	endclocking
	default disable iff (!rstn_in);

	property p_oe_idle;
		strb_s |=> !serial_output_line_oe_out;
	endproperty
	a_oe_idle: assert property (p_oe_idle) else $error("output driven while idle"); // RULE3
	property p_shift_rise;
		rise |=> shift_in[0] == $past(din_s) && shift_in[15:1] == $past(shift_in[14:0]);
	endproperty
	a_shift_rise: assert property (p_shift_rise) else $error("input not shifted"); // RULE1
	property p_no_shift_idle;
		strb_s |=> $stable(shift_in);
	endproperty
	a_no_shift_idle: assert property (p_no_shift_idle) else $error("shift while idle"); // RULE2
	property p_write_cfg;
		frame_ok && rx_wr && rx_addr == bdsrp_pkg::ADDR_TIMING
			|=> cfg_reg[0] == $past(shift_in[10:1]);
	endproperty
	a_write_cfg: assert property (p_write_cfg) else $error("write not stored"); // RULE8
	property p_bad_frame;
		frame_bad |=> err_flag && $stable(cfg_reg[1]) && $stable(cfg_reg[0]);
	endproperty
	a_bad_frame: assert property (p_bad_frame) else $error("bad frame accepted"); // RULE5
	property p_err_hold;
		err_flag && !status_clear |=> err_flag;
	endproperty
	a_err_hold: assert property (p_err_hold) else $error("error flag lost"); // RULE6
	property p_read_nowrite;
		frame_ok && !rx_wr |=> $stable(cfg_reg[0]) && $stable(cfg_reg[1]) && $stable(cfg_reg[2]);
	endproperty
	a_read_nowrite: assert property (p_read_nowrite) else $error("read wrote data"); // RULE9
	property p_first_ff;
		fall_evt |=> serial_output_line_out == $past(status_word[15]) ##1
			serial_output_line_out == $past(tx_word[15]);
	endproperty
	a_first_ff: assert property (p_first_ff) else $error("summary not first"); // RULE13
	property p_parity;
		active && tx_idx == bdsrp_pkg::TX_IDX_LAST && !fall_evt |-> ^tx_word;
	endproperty
	a_parity: assert property (p_parity) else $error("parity not odd"); // RULE10
	property p_ro_clear;
		frame_ok && !rx_wr && rx_addr == bdsrp_pkg::ADDR_RO0 && diag_set_in[0] == 10'h000
			|=> ro_reg[0] == 10'h000;
	endproperty
	a_ro_clear: assert property (p_ro_clear) else $error("result not cleared"); // RULE15
	property p_first5;
		rise && rx_cnt == bdsrp_pkg::RX_CNT_WR |=> $stable(tx_word[15:11]);
	endproperty
	a_first5: assert property (p_first5) else $error("status top changed"); // RULE16
	property p_cnt_fall;
		fall_evt |=> rx_cnt == 5'h00 && tx_idx == 4'h0;
	endproperty
	a_cnt_fall: assert property (p_cnt_fall) else $error("counters not cleared"); // RULE24
	c_write: cover property (frame_ok && rx_wr);
	c_read: cover property (frame_ok && !rx_wr);
	c_bad: cover property (frame_bad);
	c_poll: cover property (end_evt && rx_cnt == 5'h00);

endmodule

// *** inc/bdsrp_pkg.sv ***
// Operation
// RULE1 - Sample input on serial clock rise
// RULE2 - Strobe high means no shifting
// RULE3 - Output undriven while strobe high
// RULE4 - Strobe rise after sixteen bits commits frame
// RULE5 - Wrong edge count: discard, flag error
// RULE6 - Error flag holds until valid write
// RULE7 - Address in top bits, then write flag
// RULE8 - Write flag stores bits ten to one
// RULE9 - Read flag: no store, send register
// RULE10 - Last bit gives odd word parity
// RULE11 - Parity never stored, computed per transfer
// RULE12 - Send msb first, change on fall
// RULE13 - Fault summary shown when strobe falls
// RULE14 - Read-only address written: send status, clear
// RULE15 - Read-only address read: send, then clear
// RULE16 - First five bits are status top
// RULE17 - Timing register: verify time, dead time
// RULE18 - Overcurrent and low-side threshold fields
// RULE19 - Two qualifier mode selector bits
// RULE20 - Disconnect and high-side threshold fields
// RULE21 - Clockless poll frame ends without error
// RULE22 - Write sends ten status bits, parity
// RULE23 - Fault summary set by any status
// RULE24 - Edge counter cleared at strobe fall
package bdsrp_pkg;

	// ********************************
	// Frame layout.
	// ********************************
	localparam int FRAME_BITS = 16;
	localparam int ADDR_MSB = 15;
	localparam int ADDR_LSB = 12;
	localparam int WR_BIT = 11;
	localparam int DATA_MSB = 10;
	localparam int DATA_LSB = 1;
	localparam logic [4:0] RX_CNT_FULL = 5'h10;
	localparam logic [4:0] RX_CNT_OVER = 5'h11;
	localparam logic [4:0] RX_CNT_WR = 5'h04;
	localparam logic [3:0] TX_IDX_LAST = 4'hf;

	// ********************************
	// Register addresses.
	// ********************************
	localparam logic [3:0] ADDR_TIMING = 4'h0;
	localparam logic [3:0] ADDR_OC_LS = 4'h1;
	localparam logic [3:0] ADDR_QUAL_HS = 4'h2;
	localparam logic [3:0] ADDR_RO0 = 4'h8;
	localparam logic [3:0] ADDR_RO1 = 4'h9;
	localparam logic [3:0] ADDR_RO2 = 4'hc;
	localparam logic [3:0] ADDR_RO3 = 4'hd;
	localparam logic [3:0] ADDR_RO4 = 4'he;

	// ********************************
	// Reset values.
	// ********************************
	localparam logic [9:0] TIMING_RESET = 10'h000;
	localparam logic [9:0] OC_LS_RESET = 10'h000;
	localparam logic [9:0] QUAL_HS_RESET = 10'h000;

	// ********************************
	// Status word bit positions.
	// ********************************
	localparam int ST_SUMMARY = 15;
	localparam int ST_POR = 14;
	localparam int ST_SERR = 13;

	// ********************************
	// Configuration field positions.
	// ********************************
	localparam int VERIFY_MSB = 9;
	localparam int VERIFY_LSB = 7;
	localparam int DEAD_MSB = 6;
	localparam int OC_MSB = 9;
	localparam int OC_LSB = 6;
	localparam int LS_MSB = 5;
	localparam int OC_QUAL_BIT = 9;
	localparam int DS_QUAL_BIT = 8;
	localparam int DISC_MSB = 7;
	localparam int DISC_LSB = 6;
	localparam int HS_MSB = 5;

	typedef struct packed {
		logic [3:0] overcurrent_verify_time;
		logic [6:0] dead_time_setting;
		logic [3:0] overcurrent_threshold;
		logic [5:0] lowside_drain_threshold;
		logic overcurrent_qualifier_select;
		logic drain_source_qualifier_select;
		logic [1:0] bridge_disconnect_threshold;
		logic [5:0] highside_drain_threshold;
	} bdsrp_cfg_t;

	typedef logic [4:0][9:0] bdsrp_diag_t;

endpackage

// *** test/bdsrp_ctrl_model.sv ***
`timescale 1ns/10ps
module bdsrp_ctrl_model (
	// Clock used to align pin changes.
	input wire logic sys_clk_in,
	// Serial link pins.
	output logic serial_clock_out,
	output logic select_strobe_low_out,
	output logic serial_input_line_out,
	input wire logic serial_output_line_in
);
	logic idle;

	initial begin
		serial_clock_out = 1'b0;
		select_strobe_low_out = 1'b1;
		serial_input_line_out = 1'b0;
		idle = 1'b1;
	end

	always @(negedge sys_clk_in) begin
		if (idle) begin
			serial_input_line_out <= ~serial_input_line_out;
		end
	end

	task automatic frame(input logic [15:0] word, input int n, input int pre,
			output logic [15:0] rx);
		int i;
		rx = 16'h0000;
		@(negedge sys_clk_in);
		idle = 1'b0;
		for (i = 0; i < pre; i++) begin
			repeat (4) @(negedge sys_clk_in);
			serial_clock_out = 1'b1;
			repeat (4) @(negedge sys_clk_in);
			serial_clock_out = 1'b0;
		end
		@(negedge sys_clk_in);
		serial_clock_out = (n == 0);
		select_strobe_low_out = 1'b0;
		for (i = 0; i < n; i++) begin
			serial_input_line_out = (i < 16) ? word[15 - i] : word[0];
			repeat (4) @(negedge sys_clk_in);
			serial_clock_out = 1'b1;
			repeat (2) @(negedge sys_clk_in);
			if (i < 16) begin
				rx[15 - i] = serial_output_line_in;
			end
			repeat (2) @(negedge sys_clk_in);
			serial_clock_out = 1'b0;
		end
		repeat (6) @(negedge sys_clk_in);
		if (n == 0) begin
			rx[15] = serial_output_line_in;
		end
		select_strobe_low_out = 1'b1;
		repeat (2) @(negedge sys_clk_in);
		serial_clock_out = 1'b0;
		repeat (8) @(negedge sys_clk_in);
		idle = 1'b1;
	endtask
endmodule

// *** test/tb_bridge_driver_serial_register_port.sv ***
`timescale 1ns/10ps
module tb_bridge_driver_serial_register_port;
	localparam logic [9:0] CFG_VAL [3] = '{10'h2a5, 10'h3c6, 10'h1d9};
	localparam logic [3:0] RO_ADDR [5] = '{4'h8, 4'h9, 4'hc, 4'hd, 4'he};
	logic sys_clk_in;
	logic rstn_in;
	logic serial_clock;
	logic strobe_low;
	logic din;
	wire dout_line;
	logic dout;
	logic dout_oe;
	logic [11:0] monitor_fault;
	bdsrp_pkg::bdsrp_diag_t diag_set;
	bdsrp_pkg::bdsrp_cfg_t cfg;
	logic serr_flag;
	logic por;
	logic serr_exp;
	logic [11:0] mon;
	int errors = 0;
	int n_tests = 0;

	assign dout_line = dout_oe ? dout : 1'bz;

	bdsrp_top i_dut (
		.sys_clk_in(sys_clk_in),
		.rstn_in(rstn_in),
		.serial_clock_in(serial_clock),
		.select_strobe_low_in(strobe_low),
		.serial_input_line_in(din),
		.serial_output_line_out(dout),
		.serial_output_line_oe_out(dout_oe),
		.monitor_fault_in(monitor_fault),
		.diag_set_in(diag_set),
		.config_out(cfg),
		.serial_error_flag_out(serr_flag)
	);

	bdsrp_ctrl_model i_ctrl (
		.sys_clk_in(sys_clk_in),
		.serial_clock_out(serial_clock),
		.select_strobe_low_out(strobe_low),
		.serial_input_line_out(din),
		.serial_output_line_in(dout_line)
	);

	// ********************************
	// Shared helpers.
	// ********************************
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			errors++;
			$display("unexpected %s: expected %h, seen %h", name, exp, seen);
		end
	endtask

	task automatic report_and_stop;
		$display("checks %0d, errors %0d", n_tests, errors);
		if (errors == 0 && n_tests > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	task automatic xfer(input logic [3:0] a, input logic wr, input logic [9:0] d, input int n,
			input int pre, output logic [15:0] rx);
		logic [14:0] body;
		body = {a, wr, d};
		i_ctrl.frame({body, ~^body}, n, pre, rx);
	endtask

	function automatic logic [15:0] exp_rx(input logic wr, input logic [9:0] regv);
		logic [15:0] st;
		logic [14:0] body;
		st = {por | serr_exp | (|mon), por, serr_exp, mon, 1'b0};
		body = {st[15:11], wr ? st[10:1] : regv};
		return {body, ~^body};
	endfunction

	// ********************************
	// Scenarios.
	// ********************************
	task automatic t_reset;
		logic [15:0] rx;
		check("reset config", 32'(cfg), 32'h0);
		check("reset error flag", 32'(serr_flag), 32'h0);
		check("idle enable", 32'(dout_oe), 32'h0);
		xfer(4'h0, 1'b1, 10'h3ff, 0, 2, rx);
		check("poll summary", 32'(rx[15]), 32'h1);
		check("poll error flag", 32'(serr_flag), 32'h0);
		check("poll config", 32'(cfg), 32'h0);
	endtask

	task automatic t_config;
		logic [15:0] rx;
		int k;
		for (k = 0; k < 3; k++) begin
			xfer(4'(k), 1'b1, CFG_VAL[k], 16, 0, rx);
			check("write echo", 32'(rx), 32'(exp_rx(1'b1, 10'h000)));
			por = 1'b0;
		end
		check("config", 32'(cfg), {2'b00, CFG_VAL[0], CFG_VAL[1], CFG_VAL[2]});
		for (k = 0; k < 3; k++) begin
			xfer(4'(k), 1'b0, ~CFG_VAL[k], 16, k, rx);
			check("read back", 32'(rx), 32'(exp_rx(1'b0, CFG_VAL[k])));
		end
		check("config kept", 32'(cfg), {2'b00, CFG_VAL[0], CFG_VAL[1], CFG_VAL[2]});
	endtask

	task automatic t_error;
		logic [15:0] rx;
		xfer(4'h0, 1'b1, 10'h0f0, 15, 0, rx);
		check("short frame flag", 32'(serr_flag), 32'h1);
		xfer(4'h1, 1'b1, 10'h0f0, 17, 0, rx);
		check("long frame config", 32'(cfg), {2'b00, CFG_VAL[0], CFG_VAL[1], CFG_VAL[2]});
		serr_exp = 1'b1;
		xfer(4'h1, 1'b0, 10'h000, 16, 0, rx);
		check("error in status", 32'(rx), 32'(exp_rx(1'b0, CFG_VAL[1])));
		check("error kept", 32'(serr_flag), 32'h1);
		xfer(4'h0, 1'b1, CFG_VAL[0], 16, 0, rx);
		serr_exp = 1'b0;
		check("error cleared", 32'(serr_flag), 32'h0);
		check("idle after frame", 32'(dout_oe), 32'h0);
	endtask

	task automatic t_monitor;
		logic [15:0] rx;
		monitor_fault = 12'h801;
		repeat (4) @(negedge sys_clk_in);
		mon = 12'h801;
		xfer(4'h2, 1'b0, 10'h000, 16, 0, rx);
		check("monitor read", 32'(rx), 32'(exp_rx(1'b0, CFG_VAL[2])));
		monitor_fault = 12'h000;
		xfer(4'h2, 1'b1, CFG_VAL[2], 16, 0, rx);
		check("monitor write", 32'(rx), 32'(exp_rx(1'b1, 10'h000)));
		mon = 12'h000;
		xfer(4'h0, 1'b1, 10'h000, 0, 0, rx);
		check("summary clear", 32'(rx[15]), 32'h0);
	endtask

	task automatic t_diag;
		logic [15:0] rx;
		int k;
		for (k = 0; k < 5; k++) begin
			diag_set[k] = 10'(10'h200 >> k);
			@(negedge sys_clk_in);
			diag_set = '0;
			xfer(RO_ADDR[k], 1'b1, 10'h3ff, 16, 0, rx);
			check("result write", 32'(rx), 32'(exp_rx(1'b1, 10'h000)));
			xfer(RO_ADDR[k], 1'b0, 10'h155, 16, 0, rx);
			check("result read", 32'(rx), 32'(exp_rx(1'b0, 10'(10'h200 >> k))));
			xfer(RO_ADDR[k], 1'b0, 10'h000, 16, 0, rx);
			check("result cleared", 32'(rx), 32'(exp_rx(1'b0, 10'h000)));
		end
		check("config after results", 32'(cfg), {2'b00, CFG_VAL[0], CFG_VAL[1], CFG_VAL[2]});
	endtask

	// ********************************
	// Clock, sequence and watchdog.
	// ********************************
	initial begin
		sys_clk_in = 1'b0;
		forever #50 sys_clk_in = ~sys_clk_in;
	end

	initial begin
		rstn_in = 1'b0;
		monitor_fault = 12'h000;
		diag_set = '0;
		por = 1'b1;
		serr_exp = 1'b0;
		mon = 12'h000;
		repeat (3) @(negedge sys_clk_in);
		rstn_in = 1'b1;
		repeat (4) @(negedge sys_clk_in);
		t_reset();
		t_config();
		t_error();
		t_monitor();
		t_diag();
		report_and_stop();
	end

	initial begin
		#3ms;
		errors++;
		report_and_stop();
	end
endmodule
